// file: src/dram_pkg.sv
package dram_pkg;
  localparam int RANKS = 2;
  localparam int BG_W = 2;
  localparam int BA_W = 2;
  localparam int ROW_W = 18;
  localparam int COL_W = 10;
  localparam int NIB_W = 4;
  localparam int BEATS = 8;
  localparam int WORD_W = NIB_W * BEATS;
  localparam int BANKS = 16;
  localparam int RD_LAT = 22;
  localparam real TCK_NS = 0.625;
  localparam int REF_COUNT = 8192;
  localparam int REF_WIN_NORMAL_MS = 64;
  localparam int REF_WIN_HOT_MS = 32;
  localparam real REF_INTERVAL_HOT_US = 3.9;
  localparam int HOT_LIMIT_C = 85;
  localparam int MEM_DEPTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h3;
  localparam logic [2:0] CMD_REF = 3'h4;

  typedef struct packed {
    logic [BG_W-1:0] bank_group;
    logic [BA_W-1:0] bank_in_group;
    logic [ROW_W-1:0] addr;
  } cmd_addr_t;

  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [WORD_W-1:0] word;
  } rd_item_t;
endpackage

// file: src/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage has no reset; contents are only read when counted valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// file: src/dram_rank_pair.sv
// Contract
// - Each rank has four bank groups of four concurrently usable banks.
// - Each rank has its own chip select, termination and clock enable.
// - A bank is named by two bank group bits and two bank bits.
// - Each access moves one 8n word, sent as eight n-bit beats.
// - Device drives read data and strobe with edges aligned to data.
// - Bursts start at addressed column, fixed length, programmed ordering; the code has no setting and always orders beats as beat XOR column low bits.
// - Address sampled with activate selects bank and row opened.
// - Chip select, bank, address with read/write select rank, bank, column.
// - Read data starts 22 link clocks after the read command.
`timescale 1ns/1ps
`default_nettype none
module dram_rank_pair
  import dram_pkg::*;
#(
  parameter int READ_LATENCY = RD_LAT,
  parameter int DEPTH = MEM_DEPTH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic [RANKS-1:0] cs_n_i,
  input wire logic [RANKS-1:0] cke_i,
  input wire logic [RANKS-1:0] odt_i,
  input wire logic [2:0] cmd_i,
  input wire cmd_addr_t ca_i,
  input wire logic [NIB_W-1:0] dq_i,
  output logic [NIB_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe_o,
  output logic [RANKS-1:0] term_on_o
);
  // Pin synchronisers
  logic [1:0] lclk_s;
  logic lclk_q;
  logic [RANKS-1:0] cs_s1, cs_s2, cke_s1, cke_s2, odt_s1, odt_s2;
  logic [2:0] cmd_s1, cmd_s2;
  cmd_addr_t ca_s1, ca_s2;
  logic [NIB_W-1:0] dq_s1, dq_s2;
  logic dqs_s1, dqs_s2, dqs_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lclk_s <= '0;
      lclk_q <= 1'b0;
      cs_s1 <= '1;
      cs_s2 <= '1;
      cke_s1 <= '0;
      cke_s2 <= '0;
      odt_s1 <= '0;
      odt_s2 <= '0;
      cmd_s1 <= '0;
      cmd_s2 <= '0;
      ca_s1 <= '0;
      ca_s2 <= '0;
      dq_s1 <= '0;
      dq_s2 <= '0;
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      lclk_s <= {lclk_s[0], link_clk_i};
      lclk_q <= lclk_s[1];
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      cke_s1 <= cke_i;
      cke_s2 <= cke_s1;
      odt_s1 <= odt_i;
      odt_s2 <= odt_s1;
      cmd_s1 <= cmd_i;
      cmd_s2 <= cmd_s1;
      ca_s1 <= ca_i;
      ca_s2 <= ca_s1;
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      dqs_s1 <= dqs_i;
      dqs_s2 <= dqs_s1;
      dqs_q <= dqs_s2;
    end
  end

  logic lk_rise, lk_fall, dqs_edge;
  assign lk_rise = lclk_s[1] && !lclk_q;
  assign lk_fall = !lclk_s[1] && lclk_q;
  assign dqs_edge = dqs_s2 != dqs_q;

  // Termination follows each rank's own pin, independent of the other
  assign term_on_o = odt_s2;

  // Command decode, sampled on the link rising edge
  logic [RANKS-1:0] sel;
  logic rank_idx;
  logic [3:0] bank_idx;
  always_comb begin
    sel = ~cs_s2 & cke_s2;
    rank_idx = sel[1] && !sel[0];
    bank_idx = {ca_s2.bank_group, ca_s2.bank_in_group};
  end
  logic cmd_take;
  assign cmd_take = lk_rise && (sel != '0) && ($countones(sel) == 1);

  // Per rank and bank open-row state; banks keep rows open independently
  logic [BANKS-1:0] open_r [RANKS], open_nxt [RANKS];
  logic [ROW_W-1:0] row_r [RANKS][BANKS], row_nxt [RANKS][BANKS];

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_BURST = 3'b100
  } st_t;
  st_t st_r, st_nxt;
  logic is_wr_r, is_wr_nxt;
  logic [5:0] lat_r, lat_nxt;
  logic [2:0] beat_r, beat_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic [$clog2(DEPTH)-1:0] loc_r, loc_nxt;
  logic [WORD_W-1:0] shf_r, shf_nxt;
  logic [WORD_W-1:0] mem_r [RANKS][DEPTH];
  logic mem_we;
  logic [NIB_W-1:0] dq_r, dq_nxt;
  logic dq_oe_r, dq_oe_nxt, dqs_r, dqs_nxt;
  logic rank_r, rank_nxt;

  // Read path buffer: core word enters, beats are drained from it
  rd_item_t fifo_in, fifo_out;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;

  word_fifo #(.WIDTH($bits(rd_item_t)), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out)
  );

  logic access_hit;
  assign access_hit = open_r[rank_idx][bank_idx];

  always_comb begin
    open_nxt = open_r;
    row_nxt = row_r;
    st_nxt = st_r;
    is_wr_nxt = is_wr_r;
    lat_nxt = lat_r;
    beat_nxt = beat_r;
    col_nxt = col_r;
    loc_nxt = loc_r;
    shf_nxt = shf_r;
    dq_nxt = dq_r;
    dq_oe_nxt = dq_oe_r;
    dqs_nxt = dqs_r;
    rank_nxt = rank_r;
    mem_we = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in = '0;
    fifo_pop = 1'b0;
    // Commands are refused while the FIFO cannot take a read word
    if (cmd_take && st_r == ST_IDLE && fifo_in_ready) begin
      unique case (cmd_s2)
        CMD_ACT: begin
          open_nxt[rank_idx][bank_idx] = 1'b1;
          row_nxt[rank_idx][bank_idx] = ca_s2.addr;
        end
        CMD_RD, CMD_WR: begin
          if (access_hit) begin
            rank_nxt = rank_idx;
            col_nxt = ca_s2.addr[COL_W-1:0];
            // Location folds row, bank and column into the small array
            loc_nxt = $clog2(DEPTH)'(row_r[rank_idx][bank_idx] ^ {14'h0, bank_idx} ^
                      {8'h0, ca_s2.addr[COL_W-1:0]});
            is_wr_nxt = (cmd_s2 == CMD_WR);
            // Word is fetched one link clock early so beat 0 leaves on the last rise
            lat_nxt = 6'(READ_LATENCY - 2);
            beat_nxt = '0;
            st_nxt = (cmd_s2 == CMD_WR) ? ST_BURST : ST_WAIT;
          end
        end
        CMD_REF: begin
          open_nxt[rank_idx] = '0;
        end
        default: begin
        end
      endcase
    end
    unique case (st_r)
      ST_IDLE: begin
        // Last beat keeps the pins for its full half period
        if (lk_rise || lk_fall) begin
          dq_oe_nxt = 1'b0;
        end
      end
      ST_WAIT: begin
        if (lk_rise) begin
          if (lat_r == 6'h0) begin
            // Whole core word fetched in one step
            fifo_in_valid = 1'b1;
            fifo_in.word = mem_r[rank_r][loc_r];
            fifo_in.col = col_r;
            st_nxt = ST_BURST;
          end else begin
            lat_nxt = lat_r - 6'h1;
          end
        end
      end
      ST_BURST: begin
        if (is_wr_r) begin
          if (dqs_edge) begin
            // Beat order follows the starting column's low bits
            shf_nxt[NIB_W*(beat_r ^ col_r[2:0]) +: NIB_W] = dq_s2;
            beat_nxt = beat_r + 3'h1;
            if (beat_r == 3'(BEATS - 1)) begin
              mem_we = 1'b1;
              st_nxt = ST_IDLE;
            end
          end
        end else if ((lk_rise || (lk_fall && beat_r != 3'h0)) && fifo_out_valid) begin
          dq_oe_nxt = 1'b1;
          dq_nxt = fifo_out.word[NIB_W*(beat_r ^ fifo_out.col[2:0]) +: NIB_W];
          dqs_nxt = lk_rise;
          beat_nxt = beat_r + 3'h1;
          if (beat_r == 3'(BEATS - 1)) begin
            fifo_pop = 1'b1;
            st_nxt = ST_IDLE;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      open_r <= '{default: '0};
      row_r <= '{default: '{default: '0}};
      st_r <= ST_IDLE;
      is_wr_r <= 1'b0;
      lat_r <= '0;
      beat_r <= '0;
      col_r <= '0;
      loc_r <= '0;
      shf_r <= '0;
      dq_r <= '0;
      dq_oe_r <= 1'b0;
      dqs_r <= 1'b0;
      rank_r <= 1'b0;
    end else begin
      open_r <= open_nxt;
      row_r <= row_nxt;
      st_r <= st_nxt;
      is_wr_r <= is_wr_nxt;
      lat_r <= lat_nxt;
      beat_r <= beat_nxt;
      col_r <= col_nxt;
      loc_r <= loc_nxt;
      shf_r <= shf_nxt;
      dq_r <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      dqs_r <= dqs_nxt;
      rank_r <= rank_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_r[rank_r][loc_r] <= shf_nxt;
    end
  end

  assign dq_o = dq_r;
  assign dq_oe_o = dq_oe_r;
  assign dqs_o = dqs_r;
  assign dqs_oe_o = dq_oe_r;
endmodule
`default_nettype wire

// file: bench/dram_rank_pair_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dram_rank_pair_properties
  import dram_pkg::*;
#(
  parameter int READ_LATENCY = RD_LAT
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic [RANKS-1:0] cs_n_i,
  input wire logic [RANKS-1:0] odt_i,
  input wire logic [NIB_W-1:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic dqs_o,
  input wire logic dqs_oe_o,
  input wire logic [RANKS-1:0] term_on_o
);
  // Bench link period in clocks; the latency window assumes it
  localparam int LINK_CLKS = 8;
  logic [15:0] age_r, age_nxt;
  always_comb begin
    age_nxt = (age_r == 16'hffff) ? age_r : age_r + 16'h1;
    if (cs_n_i != 2'h3) age_nxt = 16'h0;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) age_r <= 16'hffff;
    else age_r <= age_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_oe_pair; dqs_oe_o == dq_oe_o; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("strobe enable split");
  property p_term; !$stable(odt_i) ##1 $stable(odt_i)[*4] |-> term_on_o == odt_i; endproperty
  a_term: assert property (p_term) else $error("termination wrong");
  property p_lat;
    $rose(dq_oe_o) |->
      age_r inside {[READ_LATENCY*LINK_CLKS-24 : READ_LATENCY*LINK_CLKS+16]};
  endproperty
  a_lat: assert property (p_lat) else $error("read data at wrong time");
  property p_hold; $changed(dqs_o) && dq_oe_o |=> (!dq_oe_o || $stable(dqs_o))[*2]; endproperty
  a_hold: assert property (p_hold) else $error("beat too short");
  property p_step; dq_oe_o && $past(dq_oe_o) && $changed(dq_o) |-> $changed(dqs_o); endproperty
  a_step: assert property (p_step) else $error("data moved without strobe");
  property p_start; $rose(dq_oe_o) |-> dqs_o && link_clk_i; endproperty
  a_start: assert property (p_start) else $error("burst start phase");
  property p_len; $rose(dq_oe_o) |-> dq_oe_o[*8]; endproperty
  a_len: assert property (p_len) else $error("burst cut short");
  property p_gap; $fell(dq_oe_o) |=> !dq_oe_o[*8]; endproperty
  a_gap: assert property (p_gap) else $error("burst without command");
endmodule
bind dram_rank_pair dram_rank_pair_properties #(.READ_LATENCY(READ_LATENCY)) props_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i), .cs_n_i(cs_n_i),
  .odt_i(odt_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
  .term_on_o(term_on_o));
`default_nettype wire

// file: bench/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
  import dram_pkg::*;
(
  input wire logic clk_i,
  output logic link_clk_o,
  output logic [RANKS-1:0] cs_n_o,
  output logic [RANKS-1:0] cke_o,
  output logic [RANKS-1:0] odt_o,
  output logic [2:0] cmd_o,
  output var cmd_addr_t ca_o,
  output logic [NIB_W-1:0] dq_o,
  output logic dqs_o,
  input wire logic [NIB_W-1:0] dq_i,
  input wire logic dqs_i,
  input wire logic dq_oe_i
);
  int rises = 0;
  initial begin
    {cs_n_o, cke_o, odt_o, cmd_o} = {2'h3, 2'h3, 2'h0, 3'h0};
    {ca_o, dq_o, dqs_o} = '0;
    link_clk_o = 1'b0;
    forever #400 link_clk_o = ~link_clk_o;
  end
  always @(posedge link_clk_o) rises++;
  // Held one whole link period so the rise is seen through the sync
  task automatic send(input logic [1:0] cs, input logic [2:0] c, input cmd_addr_t a);
    @(negedge link_clk_o);
    @(posedge clk_i);
    #1 {cs_n_o, cmd_o, ca_o} = {cs, c, a};
    @(negedge link_clk_o);
    @(posedge clk_i);
    #1 {cs_n_o, cmd_o} = {2'h3, ~c};
  endtask
  task automatic wr(input logic [WORD_W-1:0] w, input logic [2:0] c);
    for (int k = 0; k < BEATS; k++) begin
      dq_o = w[NIB_W*(k^c) +: NIB_W];
      repeat (2) @(posedge clk_i);
      #1 dqs_o = ~dqs_o;
      repeat (2) @(posedge clk_i);
      #1;
    end
    // Released line shows the inverse, never a stale copy
    dq_o = ~dq_o;
  endtask
  task automatic rd(input logic [2:0] c, output logic [WORD_W-1:0] w, output int lat,
                    output logic ok);
    int r0, n;
    {r0, n, ok, w} = {rises, 32'h0, 1'b1, 32'h0};
    while (dq_oe_i !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #1 n++;
    end
    lat = rises - r0;
    repeat (2) @(posedge clk_i);
    #1;
    for (int k = 0; k < BEATS; k++) begin
      w[NIB_W*(k^c) +: NIB_W] = dq_i;
      if (dqs_i !== ~k[0]) ok = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/dram_rank_pair_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_rank_pair_tb;
  import dram_pkg::*;
  logic clk_i, resetn_i, link_clk, dqs_w, dqs_r, dq_oe, dqs_oe, dqs_bus;
  logic [RANKS-1:0] cs_n, cke, odt, term_on;
  logic [2:0] cmd;
  cmd_addr_t ca;
  logic [NIB_W-1:0] dq_w, dq_r, dq_bus;
  int n_fail = 0;
  int comparisons = 0;
  assign dq_bus = dq_oe ? dq_r : dq_w;
  assign dqs_bus = dqs_oe ? dqs_r : dqs_w;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ctrl_model ctrl_u (.clk_i(clk_i), .link_clk_o(link_clk), .cs_n_o(cs_n), .cke_o(cke),
    .odt_o(odt), .cmd_o(cmd), .ca_o(ca), .dq_o(dq_w), .dqs_o(dqs_w), .dq_i(dq_bus),
    .dqs_i(dqs_bus), .dq_oe_i(dq_oe));
  dram_rank_pair dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk),
    .cs_n_i(cs_n), .cke_i(cke), .odt_i(odt), .cmd_i(cmd), .ca_i(ca), .dq_i(dq_bus),
    .dq_o(dq_r), .dq_oe_o(dq_oe), .dqs_i(dqs_bus), .dqs_o(dqs_r), .dqs_oe_o(dqs_oe),
    .term_on_o(term_on));
  task automatic chk_v(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected count at %0t: %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic put(input logic [1:0] cs, input logic [3:0] bk, input logic [9:0] col,
                     input logic [WORD_W-1:0] w);
    ctrl_u.send(cs, CMD_ACT, {bk, 18'h00005});
    ctrl_u.send(cs, CMD_WR, {bk, 8'h00, col});
    ctrl_u.wr(w, col[2:0]);
  endtask
  task automatic get(input logic [1:0] cs, input logic [3:0] bk, input logic [9:0] col,
                     input logic [WORD_W-1:0] exp);
    logic [WORD_W-1:0] w;
    int lat;
    logic ok;
    ctrl_u.send(cs, CMD_RD, {bk, 8'h00, col});
    ctrl_u.rd(col[2:0], w, lat, ok);
    chk_v(w, exp);
    chk_n(lat, RD_LAT);
    chk_v(WORD_W'(ok), 32'h1);
  endtask
  // Refused commands must leave the data pins undriven for a full latency
  task automatic quiet(input logic [1:0] cs, input logic [3:0] bk);
    logic seen;
    seen = 1'b0;
    ctrl_u.send(cs, CMD_RD, {bk, 8'h00, 10'h003});
    repeat (240) begin
      @(posedge clk_i);
      #1 if (dq_oe !== 1'b0) seen = 1'b1;
    end
    chk_v(WORD_W'(seen), 32'h0);
  endtask
  task automatic t_bank();
    put(2'h2, 4'h6, 10'h003, 32'h1234abcd);
    put(2'h2, 4'h9, 10'h011, 32'hfeed0042);
    get(2'h2, 4'h6, 10'h003, 32'h1234abcd);
    get(2'h2, 4'h9, 10'h011, 32'hfeed0042);
  endtask
  task automatic t_rank();
    put(2'h1, 4'h6, 10'h003, 32'h5a5ac3c3);
    get(2'h2, 4'h6, 10'h003, 32'h1234abcd);
    get(2'h1, 4'h6, 10'h003, 32'h5a5ac3c3);
  endtask
  task automatic t_refuse();
    quiet(2'h0, 4'h6);
    ctrl_u.cke_o = 2'h2;
    quiet(2'h2, 4'h6);
    ctrl_u.cke_o = 2'h3;
    ctrl_u.send(2'h2, CMD_REF, '0);
    quiet(2'h2, 4'h6);
  endtask
  task automatic t_term();
    for (int i = 0; i < 4; i++) begin
      ctrl_u.odt_o = 2'(i);
      repeat (8) @(posedge clk_i);
      #1 chk_v(WORD_W'(term_on), WORD_W'(i));
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_bank();
    t_rank();
    t_refuse();
    t_term();
    end_of_test();
  end
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
